// >>> rtl/lpmc_map.vh
// Register offsets, field positions, reset values and timing counts of the low-power controller
// Assumes a 32-bit AHB-Lite slave with word-aligned registers
`ifndef LPMC_MAP_VH
`define LPMC_MAP_VH
// Register byte offsets
`define LPMC_CTRL_OFS 8'h00
`define LPMC_STAT_OFS 8'h04
`define LPMC_GATE_OFS 8'h08
`define LPMC_WAKE_OFS 8'h0C
// Control field positions
`define LPMC_MODE_LSB 0
`define LPMC_MODE_MSB 1
`define LPMC_WDKEEP_BIT 2
`define LPMC_RETAIN_LSB 8
`define LPMC_RETAIN_MSB 9
`define LPMC_FLASHSLEEP_BIT 16
`define LPMC_RAMRUN_BIT 17
`define LPMC_QUALEN_BIT 18
// Status bit that a write of one clears
`define LPMC_SEEN_BIT 8
// Mode encodings
`define LPMC_MODE_IDLE 2'h0
`define LPMC_MODE_STANDBY 2'h1
`define LPMC_MODE_HALT 2'h2
`define LPMC_MODE_HIBERNATE 2'h3
// Retention field values
`define LPMC_RETAIN_KEEP 2'h0
`define LPMC_RETAIN_OFF 2'h1
// Reset values
`define LPMC_CTRL_RST 32'h0000_0000
// Idle wake latency bounds in system clock cycles
`define LPMC_LAT_FLASH_ACTIVE 14'h0028
`define LPMC_LAT_FLASH_SLEEP 14'h1A2C
`define LPMC_LAT_RAM 14'h0019
// Edges from a wake pin edge to the wake state: two sync stages and the entry edge
`define LPMC_WAKE_PIPE 14'h0003
// Width of the wake latency counter
`define LPMC_CNT_W 14
`endif

// >>> rtl/lpmc_sync2.v
// Two flip-flop synchroniser for a bus of asynchronous levels
// Assumes the inputs come from pins or another clock
`timescale 1ns/100ps
module lpmc_sync2 #(
   parameter WIDTH = 1
) (
   input wire clk_sys,
   input wire rst,
   input wire [WIDTH-1:0] asyncIn,
   output reg [WIDTH-1:0] syncOut
);
   reg [WIDTH-1:0] stageOne;
   // Only the second stage reads the first
   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         stageOne <= {WIDTH{1'b0}};
         syncOut <= {WIDTH{1'b0}};
      end else begin
         stageOne <= asyncIn;
         syncOut <= stageOne;
      end
   end
endmodule // lpmc_sync2

// >>> rtl/lpmc_low_power_mode_controller.v
// Low-power mode controller: clock gates, oscillator and memory power, idle wake sequencing
// Assumes an AHB-Lite master on clk_sys; wake pins and reset pin are asynchronous
//
// Local design decisions: the AHB-Lite interface to the registers and the register addresses.
`include "lpmc_map.vh"
`timescale 1ns/100ps
// Function
// - Idle gates core clock; standby gates more
// - Halt gates clocks, powers crystal down
// - Halt keeps watchdog clock when keep-alive set
// - Halt powers internal oscillators down unless keep-alive
// - Hibernate powers down peripherals, oscillators, sets analog low power
// - Retention field decides low RAM power in hibernate
// - Hibernate powers down other RAM blocks
// - Hibernate holds I/O outputs frozen
// - Interrupt, watchdog or reset pin wakes idle
// - Flash active resume within 40 cycles
// - Flash asleep resume within 6700 cycles
// - RAM run resume within 25 cycles
module lpmc_low_power_mode_controller #(
   parameter LAT_FLASH_SLEEP = `LPMC_LAT_FLASH_SLEEP
) (
   input wire clk_sys,
   input wire rst,
   input wire hsel,
   input wire [31:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire [2:0] hsize,
   input wire [31:0] hwdata,
   input wire hready,
   output wire hreadyout,
   output wire hresp,
   output reg [31:0] hrdata,
   input wire idleExec,
   input wire enabledIrq,
   input wire watchdogIrq,
   input wire externalResetPin,
   input wire wakeQualified,
   output wire cpuClockInputEn,
   output wire systemClockEn,
   output wire cpuCoreClockEn,
   output wire peripheralSystemClockEn,
   output wire watchdogClockEn,
   output wire auxiliaryPllClockEn,
   output wire crystalOscillatorPowerEn,
   output wire internalOscillatorOnePowerEn,
   output wire internalOscillatorTwoPowerEn,
   output wire digitalPeripheralPowerEn,
   output wire analogLowPower,
   output wire lowRamPowerEn,
   output wire sharedRamPowerEn,
   output wire ioHold,
   output wire cpuResume
);
   // ****************************************************************
   // States and locals
   // ****************************************************************
   localparam ST_RUN = 2'h0;
   localparam ST_LOW = 2'h1;
   localparam ST_WAKE = 2'h2;
   // The sleep bound may be overridden by a wider integer, so cut it to the counter
   localparam [`LPMC_CNT_W-1:0] LAT_SLEEP = LAT_FLASH_SLEEP[`LPMC_CNT_W-1:0];
   localparam [`LPMC_CNT_W-1:0] LAT_ACTIVE = `LPMC_LAT_FLASH_ACTIVE;
   localparam [`LPMC_CNT_W-1:0] LAT_RAM = `LPMC_LAT_RAM;
   // Edges already spent when the sequencer first sees a wake
   localparam [`LPMC_CNT_W-1:0] WAKE_PIPE = `LPMC_WAKE_PIPE;

   reg [1:0] state;
   reg [1:0] next_state;
   reg [1:0] activeMode;
   reg [1:0] cfgMode;
   reg cfgWdKeep;
   reg [1:0] cfgRetain;
   reg cfgFlashSleep;
   reg cfgRamRun;
   reg [`LPMC_CNT_W-1:0] latCnt;
   reg [`LPMC_CNT_W-1:0] lastLatency;
   reg [7:0] wakeCount;
   reg wakeSeen;
   reg addrValid;
   reg addrWrite;
   reg [7:0] addrOfs;
   wire [2:0] wakeSync;
   wire wakeAny;
   wire inLow;
   wire isIdle;
   wire isStandby;
   wire isHalt;
   wire isHib;
   wire deepGate;
   wire oscDown;
   wire [31:0] ctrlWord;
   wire [31:0] statWord;
   wire [31:0] gateWord;

   // ****************************************************************
   // Synchronise wake sources
   // ****************************************************************
   lpmc_sync2 #(
      .WIDTH(3)
   ) uWakeSync (
      .clk_sys(clk_sys),
      .rst(rst),
      .asyncIn({externalResetPin, watchdogIrq, enabledIrq}),
      .syncOut(wakeSync)
   );

   // The reset pin is used here only as a wake level; the device reset lives elsewhere.
   // A level held low by the qualifier never counts, however long it stands.
   // Any accepted wake source ends idle
   assign wakeAny = (|wakeSync) & wakeQualified;

   // ****************************************************************
   // Mode sequencer
   // ****************************************************************
   // Latency bound chosen by where the CPU runs from.
   // Running from RAM takes precedence over the flash sleep setting, since flash
   // power-up does not stand in the way of a fetch from RAM.
   function [`LPMC_CNT_W-1:0] latBound;
      input ramRun;
      input flashSleep;
      begin
         if (ramRun) begin
            latBound = LAT_RAM;
         end else if (flashSleep) begin
            latBound = LAT_SLEEP;
         end else begin
            latBound = LAT_ACTIVE;
         end
      end
   endfunction

   // Next state: idle instruction enters, wake returns
   // A wake seen in any low-power mode ends the stay; the mode does not matter here
   always @* begin
      next_state = state;
      case (state)
         ST_RUN: begin
            if (idleExec) begin
               next_state = ST_LOW;
            end
         end
         ST_LOW: begin
            if (wakeAny) begin
               next_state = ST_WAKE;
            end
         end
         ST_WAKE: begin
            if (latCnt == {`LPMC_CNT_W{1'b0}}) begin
               next_state = ST_RUN;
            end
         end
         default: begin
            next_state = ST_RUN;
         end
      endcase
   end

   // State, latched mode and wake latency counter
   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         state <= ST_RUN;
         activeMode <= `LPMC_MODE_IDLE;
         latCnt <= {`LPMC_CNT_W{1'b0}};
         lastLatency <= {`LPMC_CNT_W{1'b0}};
         wakeCount <= 8'h00;
      end else begin
         state <= next_state;
         if (state == ST_RUN && idleExec) begin
            activeMode <= cfgMode;
         end
         if (state == ST_LOW && wakeAny) begin
            // The pin edge is already three edges old here, so the count is shortened
            // to keep the whole pin-to-resume span inside the bound
            latCnt <= latBound(cfgRamRun, cfgFlashSleep) - WAKE_PIPE;
            lastLatency <= latBound(cfgRamRun, cfgFlashSleep);
            wakeCount <= wakeCount + 8'h01;
         end else if (state == ST_WAKE && latCnt != {`LPMC_CNT_W{1'b0}}) begin
            latCnt <= latCnt - 1'b1;
         end
      end
   end

   assign inLow = (state != ST_RUN);
   assign isIdle = inLow && (activeMode == `LPMC_MODE_IDLE);
   assign isStandby = inLow && (activeMode == `LPMC_MODE_STANDBY);
   assign isHalt = inLow && (activeMode == `LPMC_MODE_HALT);
   assign isHib = inLow && (activeMode == `LPMC_MODE_HIBERNATE);

   // ****************************************************************
   // Clock gates and power controls
   // ****************************************************************
   // The mode is latched at entry, but keep-alive and retention are read live:
   // software must not rewrite them while the device is in a low-power mode.
   // Standby, halt and hibernate all stop the shared system clocks
   assign deepGate = isStandby | isHalt | isHib;
   // Halt without keep-alive, or hibernate, stops the internal oscillators
   assign oscDown = (isHalt & ~cfgWdKeep) | isHib;
   // Core clock stops in every low-power mode
   assign cpuCoreClockEn = ~inLow;
   // Shared clocks stop beyond idle
   assign cpuClockInputEn = ~deepGate;
   assign systemClockEn = ~deepGate;
   assign peripheralSystemClockEn = ~deepGate;
   // The auxiliary PLL clock survives idle and standby only
   assign auxiliaryPllClockEn = ~(isHalt | isHib);
   // Watchdog survives halt only when kept alive
   assign watchdogClockEn = ~oscDown;
   // Crystal oscillator runs in idle and standby only
   assign crystalOscillatorPowerEn = ~(isHalt | isHib);
   // Both internal oscillators follow the keep-alive decision together
   assign internalOscillatorOnePowerEn = ~oscDown;
   assign internalOscillatorTwoPowerEn = ~oscDown;
   // Hibernate power domains
   assign digitalPeripheralPowerEn = ~isHib;
   assign analogLowPower = isHib;
   assign lowRamPowerEn = ~(isHib & (cfgRetain == `LPMC_RETAIN_OFF));
   assign sharedRamPowerEn = ~isHib;
   assign ioHold = isHib;
   // One-cycle pulse when the CPU may fetch again
   // It rises when the shortened count runs out; the state returns to run next edge
   assign cpuResume = (state == ST_WAKE) && (latCnt == {`LPMC_CNT_W{1'b0}});

   // Sticky record that a hibernate left shared RAM lost
   // Hibernate wins over a clear in the same cycle, so a loss is never missed
   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         wakeSeen <= 1'b0;
      end else if (isHib) begin
         wakeSeen <= 1'b1;
      end else if (addrValid && addrWrite && addrOfs == `LPMC_STAT_OFS &&
                   hwdata[`LPMC_SEEN_BIT]) begin
         wakeSeen <= 1'b0;
      end
   end

   // ****************************************************************
   // AHB-Lite slave
   // ****************************************************************
   // No register access needs a wait state, so the slave never stretches a transfer
   // and never signals an error; unmapped offsets read zero and ignore writes
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;

   // Address phase capture
   // Writes land at the end of the data phase, when hwdata stands
   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         addrValid <= 1'b0;
         addrWrite <= 1'b0;
         addrOfs <= 8'h00;
      end else if (hready) begin
         addrValid <= hsel & htrans[1];
         addrWrite <= hwrite;
         addrOfs <= haddr[7:0];
      end
   end

   // Control register writes
   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         cfgMode <= `LPMC_MODE_IDLE;
         cfgWdKeep <= 1'b0;
         cfgRetain <= `LPMC_RETAIN_KEEP;
         cfgFlashSleep <= 1'b0;
         cfgRamRun <= 1'b0;
      end else if (addrValid && addrWrite && addrOfs == `LPMC_CTRL_OFS) begin
         cfgMode <= hwdata[`LPMC_MODE_MSB:`LPMC_MODE_LSB];
         cfgWdKeep <= hwdata[`LPMC_WDKEEP_BIT];
         cfgRetain <= hwdata[`LPMC_RETAIN_MSB:`LPMC_RETAIN_LSB];
         cfgFlashSleep <= hwdata[`LPMC_FLASHSLEEP_BIT];
         cfgRamRun <= hwdata[`LPMC_RAMRUN_BIT];
      end
   end

   // Control word read back as written, unused bits zero
   assign ctrlWord = {14'h0000, cfgRamRun, cfgFlashSleep, 6'h00, cfgRetain, 5'h00,
                      cfgWdKeep, cfgMode};
   // Status layout: state, latched mode, synced wake inputs, hibernate-seen flag and
   // the number of accepted wakes
   assign statWord = {8'h00, wakeCount, 7'h00, wakeSeen, 1'b0, wakeSync, activeMode, state};
   // Gate vector in the order of the output ports, bit 0 first
   assign gateWord = {18'h0_0000, ioHold, sharedRamPowerEn, lowRamPowerEn, analogLowPower,
                      digitalPeripheralPowerEn, internalOscillatorTwoPowerEn,
                      internalOscillatorOnePowerEn, crystalOscillatorPowerEn,
                      auxiliaryPllClockEn, watchdogClockEn, peripheralSystemClockEn,
                      cpuCoreClockEn, systemClockEn, cpuClockInputEn};

   // Read data registered in the address phase
   // so that they stand through the whole data phase
   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         hrdata <= 32'h0000_0000;
      end else if (hready && hsel && htrans[1] && !hwrite) begin
         case (haddr[7:0])
            `LPMC_CTRL_OFS: hrdata <= ctrlWord;
            `LPMC_STAT_OFS: hrdata <= statWord;
            `LPMC_GATE_OFS: hrdata <= gateWord;
            `LPMC_WAKE_OFS: hrdata <= {18'h0_0000, lastLatency};
            default: hrdata <= 32'h0000_0000;
         endcase
      end
   end
endmodule // lpmc_low_power_mode_controller

// >>> tb/lpmc_monitor.sv
// Port assertions for the low-power mode controller
// Assumes binding into the controller; one clock, async reset rst
`timescale 1ns/100ps
module lpmc_monitor #(
   parameter LAT_FLASH_SLEEP = 6700
) (
   input wire clk_sys,
   input wire rst,
   input wire idleExec,
   input wire enabledIrq,
   input wire watchdogIrq,
   input wire externalResetPin,
   input wire wakeQualified,
   input wire hreadyout,
   input wire hresp,
   input wire cpuClockInputEn,
   input wire systemClockEn,
   input wire cpuCoreClockEn,
   input wire peripheralSystemClockEn,
   input wire watchdogClockEn,
   input wire auxiliaryPllClockEn,
   input wire crystalOscillatorPowerEn,
   input wire internalOscillatorOnePowerEn,
   input wire internalOscillatorTwoPowerEn,
   input wire digitalPeripheralPowerEn,
   input wire analogLowPower,
   input wire sharedRamPowerEn,
   input wire ioHold,
   input wire cpuResume
);
   // ********
   // Checks
   // ********
   reg [15:0] wakeCnt;
   wire wakeAny = enabledIrq | watchdogIrq | externalResetPin;
   // Cycles since a qualified wake while gated
   always @(posedge clk_sys or posedge rst) begin
      if (rst)
         wakeCnt <= 16'h0000;
      else if (cpuCoreClockEn)
         wakeCnt <= 16'h0000;
      else if ((wakeAny && wakeQualified) || wakeCnt != 16'h0000)
         wakeCnt <= wakeCnt + 16'h0001;
   end
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);
   sequence sRunIdle;
      idleExec && cpuCoreClockEn;
   endsequence
   sequence sGated;
      !cpuCoreClockEn;
   endsequence
   chk_entry_gates: assert property (sRunIdle |=> sGated ##1 sGated)
      else $error("core clock not gated after idle");
   chk_idle_mix: assert property (!cpuCoreClockEn && systemClockEn && !ioHold
      |-> cpuClockInputEn && peripheralSystemClockEn) else $error("idle gates too much");
   chk_standby_keep: assert property (!systemClockEn && auxiliaryPllClockEn && !ioHold
      |-> watchdogClockEn && !cpuClockInputEn && !peripheralSystemClockEn)
      else $error("standby gating wrong");
   chk_halt_osc: assert property (!auxiliaryPllClockEn && !ioHold
      |-> !crystalOscillatorPowerEn && !systemClockEn
      && watchdogClockEn == internalOscillatorOnePowerEn) else $error("halt power wrong");
   chk_osc_pair: assert property (internalOscillatorOnePowerEn == internalOscillatorTwoPowerEn)
      else $error("oscillators differ");
   chk_hib_power: assert property (ioHold |-> analogLowPower
      && !digitalPeripheralPowerEn && !sharedRamPowerEn) else $error("hibernate power wrong");
   chk_hib_hold: assert property (ioHold && !cpuResume |=> ioHold)
      else $error("pin hold dropped early");
   chk_resume_run: assert property (cpuResume |=> cpuCoreClockEn && !cpuResume && !ioHold)
      else $error("no return to run");
   // The count reaches the bound plus one on the edge that returns to run
   chk_wake_bound: assert property (wakeCnt <= LAT_FLASH_SLEEP + 1)
      else $error("wake latency too long");
   chk_bus_okay: assert property (hreadyout && !hresp) else $error("bus response wrong");
endmodule // lpmc_monitor
bind lpmc_low_power_mode_controller lpmc_monitor #(.LAT_FLASH_SLEEP(LAT_FLASH_SLEEP)) mon (.*);

// >>> tb/lpmc_cpu_model.sv
// CPU core and wake sources facing the controller
// Assumes clk_sys; wake lines are active high levels, low at rest
`timescale 1ns/100ps
module lpmc_cpu_model (
   input wire clk_sys,
   input wire cpuResume,
   output logic idleExec,
   output logic [2:0] wakeSrc
);
   // ********
   // Stimulus
   // ********
   initial begin
      idleExec = 1'b0;
      wakeSrc = 3'h0;
   end
   // One-cycle idle instruction pulse
   task automatic enter_idle();
      idleExec <= 1'b1;
      @(posedge clk_sys);
      idleExec <= 1'b0;
   endtask
   // Pulse one source for a fixed span without waiting for resume
   task automatic pulse(input int s, input int w);
      wakeSrc[s] <= 1'b1;
      repeat (w) @(posedge clk_sys);
      wakeSrc <= 3'h0;
   endtask
   // Raise one source after a gap, count cycles until resume
   task automatic wake(input int s, output int lat);
      int w;
      w = 2 + $urandom % 3;
      repeat (5 + $urandom % 4) @(posedge clk_sys);
      wakeSrc[s] <= 1'b1;
      lat = 0;
      do begin
         @(posedge clk_sys);
         lat++;
         if (lat == w)
            wakeSrc <= 3'h0;
      end while (cpuResume !== 1'b1 && lat < 8000);
   endtask
endmodule // lpmc_cpu_model

// >>> tb/tb.sv
// Self-checking bench of the low-power mode controller
// Assumes the controller, its map header and the CPU model
`timescale 1ns/100ps
module tb;
   // ********
   // Bench
   // ********
   localparam int LSLEEP = 50;
   logic clk_sys = 0, rst = 1, hwrite = 0, wakeQualified = 1;
   logic [31:0] haddr = 0, hwdata = 0, rd, ctrl;
   logic [1:0] htrans = 0;
   wire hreadyout, hresp, idleExec, cpuResume;
   wire [31:0] hrdata;
   wire [2:0] src;
   wire [13:0] gate;
   int err_total = 0, samples_checked = 0, lat, n, mode, sel, wd, ret;
   lpmc_low_power_mode_controller #(.LAT_FLASH_SLEEP(LSLEEP)) dut (.clk_sys(clk_sys),
      .rst(rst), .hsel(1'b1), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
      .hresp(hresp), .hrdata(hrdata), .idleExec(idleExec), .enabledIrq(src[0]),
      .watchdogIrq(src[1]), .externalResetPin(src[2]), .wakeQualified(wakeQualified),
      .cpuClockInputEn(gate[0]), .systemClockEn(gate[1]), .cpuCoreClockEn(gate[2]),
      .peripheralSystemClockEn(gate[3]), .watchdogClockEn(gate[4]),
      .auxiliaryPllClockEn(gate[5]), .crystalOscillatorPowerEn(gate[6]),
      .internalOscillatorOnePowerEn(gate[7]), .internalOscillatorTwoPowerEn(gate[8]),
      .digitalPeripheralPowerEn(gate[9]), .analogLowPower(gate[10]),
      .lowRamPowerEn(gate[11]), .sharedRamPowerEn(gate[12]), .ioHold(gate[13]),
      .cpuResume(cpuResume));
   lpmc_cpu_model cpu (.clk_sys(clk_sys), .cpuResume(cpuResume), .idleExec(idleExec),
      .wakeSrc(src));
   // Clock and watchdog
   initial forever #5 clk_sys = ~clk_sys;
   initial begin
      #200_000;
      err_total++;
      end_sim();
   end
   // Expected gate vector in a low-power mode
   function automatic logic [13:0] exp_gate(int m, int k, int r);
      case (m)
         0: return 14'h1BFB;
         1: return 14'h1BF0;
         2: return k ? 14'h1B90 : 14'h1A00;
         default: return r ? 14'h2400 : 14'h2C00;
      endcase
   endfunction
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         err_total++;
         $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   // Single AHB-Lite word transfer
   task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
      haddr <= a;
      hwrite <= wr;
      htrans <= 2'h2;
      do @(posedge clk_sys); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clk_sys); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask
   task automatic end_sim();
      $display("checks %0d mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   // Every mode, latency case and wake source
   initial begin
      void'($urandom(80));
      repeat (8) @(posedge clk_sys);
      rst <= 1'b0;
      @(posedge clk_sys);
      bus(1'b0, 32'h0000_0000, 32'h0000_0000);
      check(rd, 32'h0000_0000);
      bus(1'b1, 32'h0000_0010, 32'hFFFF_FFFF);
      bus(1'b0, 32'h0000_0010, 32'h0000_0000);
      check(rd, 32'h0000_0000);
      for (int i = 0; i < 12; i++) begin
         mode = i % 4;
         sel = (i / 4) % 3;
         wd = $urandom % 2;
         ret = $urandom % 2;
         n = sel == 0 ? 25 : (sel == 1 ? 40 : LSLEEP);
         ctrl = mode | (wd << 2) | (ret << 8) | ((sel == 2) << 16) | ((sel == 0) << 17);
         // Software owns the PLL; the bench has none to stop before a halt write
         bus(1'b1, 32'h0000_0000, ctrl);
         bus(1'b0, 32'h0000_0000, 32'h0000_0000);
         check(rd, ctrl);
         cpu.enter_idle();
         @(posedge clk_sys);
         check(gate & (mode == 3 ? 14'h3FC0 : 14'h3FFF), exp_gate(mode, wd, ret));
         bus(1'b0, 32'h0000_0008, 32'h0000_0000);
         check(rd[13:0] & (mode == 3 ? 14'h3FC0 : 14'h3FFF), exp_gate(mode, wd, ret));
         cpu.wake(i % 3, lat);
         check(lat - 1 <= n, 1'b1);
         @(posedge clk_sys);
         check(gate, 14'h1BFF);
         bus(1'b0, 32'h0000_000C, 32'h0000_0000);
         check(rd, n);
         $display("test %0d mode %0d done", i, mode);
      end
      // Corner: status shows the hibernate flag and wake count; a write clears the flag
      bus(1'b0, 32'h0000_0004, 32'h0000_0000);
      check(rd, 32'h000C_010C);
      bus(1'b1, 32'h0000_0004, 32'h0000_0100);
      bus(1'b0, 32'h0000_0004, 32'h0000_0000);
      check(rd, 32'h000C_000C);
      // Corner: an unqualified wake pulse leaves the sequencer in the low state
      cpu.enter_idle();
      wakeQualified <= 1'b0;
      repeat (5) @(posedge clk_sys);
      cpu.pulse(1, 4);
      repeat (4) @(posedge clk_sys);
      bus(1'b0, 32'h0000_0004, 32'h0000_0000);
      check(rd, 32'h000C_010D);
      wakeQualified <= 1'b1;
      cpu.wake(2, lat);
      check(lat - 1 <= n, 1'b1);
      $display("test corner done");
      end_sim();
   end
endmodule // tb
